// >>> rtl/rate_enable_pkg.sv
package rate_enable_pkg;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_RATE_EN   = 8'h00;
   localparam logic [7:0] OFS_DETECT    = 8'h04;
   localparam logic [7:0] OFS_COUNT     = 8'h08;
   localparam logic [7:0] OFS_THRESHOLD = 8'h0C;
   localparam logic [7:0] OFS_CAP_ATTR  = 8'h10;
   localparam logic [7:0] OFS_CAP_DATA  = 8'h14;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h18;
   localparam logic [7:0] OFS_IRQ_CLR   = 8'h1C;
   localparam logic [7:0] OFS_IRQ_EN    = 8'h20;

   // ==========================================================
   // enable bit positions
   localparam int BIT_IMPL_SPEC     = 0;
   localparam int BIT_CS_CRC        = 9;
   localparam int BIT_ACK_BAD_ID    = 10;
   localparam int BIT_NOT_ACCEPTED  = 11;
   localparam int BIT_PKT_BAD_ID    = 12;
   localparam int BIT_PKT_CRC       = 13;
   localparam int BIT_PKT_OVERSIZE  = 14;
   localparam int BIT_LR_BAD_ID     = 26;
   localparam int BIT_PROTOCOL      = 27;
   localparam int BIT_DELINEATION   = 29;
   localparam int BIT_UNEXP_ACK     = 30;
   localparam int BIT_LINK_TIMEOUT  = 31;

   // writable bits; reserved 1..8, 15..25, 28 stay zero
   localparam logic [31:0] RATE_EN_MASK  = 32'hEC00_7E01;
   localparam logic [31:0] RATE_EN_RESET = 32'h0000_0000;
   // classes whose capture contents are not valid
   localparam logic [31:0] NO_CAPTURE    = 32'hA400_0000;

   // irq status bit positions
   localparam int IRQ_THRESHOLD = 0;
   localparam int IRQ_CAPTURE   = 1;
   localparam int IRQ_W         = 2;

   // implementation-specific error causes
   typedef struct packed {
      logic reservedTransport;
      logic unmappedDest;
      logic retryLimit;
   } implCause_type;

   // words offered for capture
   typedef struct packed {
      logic [31:0] errorWord;
      logic [31:0] lastRxWord;
   } captureWords_type;

endpackage

// >>> rtl/port_error_rate_enable.sv
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
module port_error_rate_enable
   import rate_enable_pkg::*;
#(
   parameter int CNT_W = 8
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             hsel,
   input  wire logic [7:0]       haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic                  hreadyout,
   output logic [31:0]           hrdata,
   output logic                  hresp,
   input  wire logic [31:0]      errEvent,
   input  wire implCause_type    implCause,
   input  wire captureWords_type capWords,
   output logic                  errorReport,
   output logic                  irq
);

   // ==========================================================
   // elaboration check
   generate
      if (CNT_W < 1 || CNT_W > 32) begin : gBadWidth
         $error("CNT_W must be 1 to 32");
      end
      // the no-capture classes must be ones that software can enable
      if ((NO_CAPTURE & ~RATE_EN_MASK) != 32'h0000_0000) begin : gBadMask
         $error("NO_CAPTURE must lie inside RATE_EN_MASK");
      end
   endgenerate

   // ==========================================================
   // helpers
   function automatic logic [4:0] lowBit(input logic [31:0] v);
      lowBit = 5'h00;
      // scans downward so the lowest set bit is written last and wins
      for (int i = 31; i >= 0; i--) begin
         if (v[i]) begin
            lowBit = 5'(i);
         end
      end
   endfunction

   function automatic logic hit(input logic [31:0] v,
                                input logic [31:0] en);
      hit = |(v & en);
   endfunction

   // ==========================================================
   // bus address phase
   logic             wrPend_r;
   logic [7:0]       wrAddr_r;
   logic [31:0]      rateEn_r;
   logic [31:0]      detect_r;
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] threshold_r;
   logic [31:0]      capAttr_r;
   logic [31:0]      capData_r;
   logic [IRQ_W-1:0] irqStat_r;
   logic [IRQ_W-1:0] irqEn_r;
   logic             take;
   logic             wrEn;
   logic [31:0]      rdNxt;

   assign take = hsel && htrans[1] && hready;

   always_ff @(posedge clk) begin
      if (srst) begin
         wrPend_r <= 1'b0;
         wrAddr_r <= 8'h00;
      end else begin
         wrPend_r <= take && hwrite && hsize == 3'b010;
         wrAddr_r <= haddr;
      end
   end

   assign wrEn = wrPend_r;

   // reads decode in the address phase, so no wait state is ever needed;
   // a read right after a write to the same register returns the old value
   always_comb begin
      rdNxt = 32'h0000_0000;
      unique case (haddr)
         OFS_RATE_EN:   rdNxt = rateEn_r & RATE_EN_MASK;
         OFS_DETECT:    rdNxt = detect_r;
         OFS_COUNT:     rdNxt = 32'(count_r);
         OFS_THRESHOLD: rdNxt = 32'(threshold_r);
         OFS_CAP_ATTR:  rdNxt = capAttr_r;
         OFS_CAP_DATA:  rdNxt = capData_r;
         OFS_IRQ_STAT:  rdNxt = 32'(irqStat_r);
         OFS_IRQ_EN:    rdNxt = 32'(irqEn_r);
         default:       rdNxt = 32'h0000_0000;
      endcase
   end

   // ==========================================================
   // bus answer: zero wait, always okay
   always_ff @(posedge clk) begin
      if (srst) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= 32'h0000_0000;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (take && !hwrite) begin
            hrdata <= rdNxt;
         end
      end
   end

   // ==========================================================
   // rate enable register
   always_ff @(posedge clk) begin
      if (srst) begin
         rateEn_r <= RATE_EN_RESET;
      // reserved positions are masked on write and again on read
      end else if (wrEn && wrAddr_r == OFS_RATE_EN) begin
         rateEn_r <= hwdata & RATE_EN_MASK;
      end
   end

   // ==========================================================
   // error detect
   logic        swDetWr;
   logic [31:0] hwErr;
   logic        hwCount;
   logic        swCount;

   // hardware events on writable classes always mark detect; only the enables gate counting
   assign swDetWr = wrEn && wrAddr_r == OFS_DETECT;
   assign hwErr   = errEvent & RATE_EN_MASK;
   assign hwCount = hit(hwErr, rateEn_r);
   assign swCount = swDetWr && hwdata != 32'h0000_0000
                    && hit(hwdata, rateEn_r);

   always_ff @(posedge clk) begin
      if (srst) begin
         detect_r <= 32'h0000_0000;
      end else if (swDetWr) begin
         detect_r <= (hwdata & RATE_EN_MASK) | hwErr;
      end else begin
         detect_r <= detect_r | hwErr;
      end
   end

   // ==========================================================
   // rate counter and threshold
   logic [CNT_W-1:0] countNxt;

   always_comb begin
      countNxt = count_r;
      // saturate at all ones so a burst cannot wrap the count back to zero
      if ((hwCount || swCount) && count_r != '1) begin
         countNxt = count_r + 1'b1;
      end
      if (wrEn && wrAddr_r == OFS_COUNT) begin
         countNxt = hwdata[CNT_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         count_r <= '0;
      end else begin
         count_r <= countNxt;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         threshold_r <= '0;
      end else if (wrEn && wrAddr_r == OFS_THRESHOLD) begin
         threshold_r <= hwdata[CNT_W-1:0];
      end
   end

   logic thrNow;

   // report only on the step onto the threshold, so neither a stuck count
   // nor a threshold write alone repeats it
   assign thrNow = threshold_r != '0 && countNxt == threshold_r
                   && countNxt != count_r;

   always_ff @(posedge clk) begin
      if (srst) begin
         errorReport <= 1'b0;
      end else begin
         errorReport <= thrNow;
      end
   end

   // ==========================================================
   // error capture
   logic [4:0]  capType;
   logic        capValid;
   logic        capLast;
   logic        capNow;
   logic [31:0] capEn;

   // capture locks once valid; of several classes in one cycle
   // the lowest enabled bit names the error type
   assign capEn   = hwErr & rateEn_r;
   assign capType = lowBit(capEn);
   assign capNow  = |capEn && !capAttr_r[31];
   assign capLast = capType == 5'(BIT_IMPL_SPEC)
                    && implCause.retryLimit;

   always_comb begin
      capValid = !NO_CAPTURE[capType];
      if (capType == 5'(BIT_IMPL_SPEC)) begin
         capValid = implCause.reservedTransport
                    || implCause.unmappedDest
                    || implCause.retryLimit;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         capAttr_r <= 32'h0000_0000;
         capData_r <= 32'h0000_0000;
      end else if (capNow && capValid) begin
         capAttr_r <= {1'b1, 23'h00_0000, capType, 3'b000};
         capData_r <= capLast ? capWords.lastRxWord
                              : capWords.errorWord;
      end else begin
         if (wrEn && wrAddr_r == OFS_CAP_ATTR) begin
            capAttr_r <= hwdata & 32'h8000_00F8;
         end
         if (wrEn && wrAddr_r == OFS_CAP_DATA
             && !capAttr_r[31]) begin
            capData_r <= hwdata;
         end
      end
   end

   // ==========================================================
   // interrupts: set wins over clear
   logic [IRQ_W-1:0] irqSet;
   logic [IRQ_W-1:0] irqClr;

   always_comb begin
      irqSet                = '0;
      irqSet[IRQ_THRESHOLD] = thrNow;
      irqSet[IRQ_CAPTURE]   = capNow && capValid;
      irqClr = '0;
      if (wrEn && wrAddr_r == OFS_IRQ_CLR) begin
         irqClr = hwdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irqStat_r <= '0;
      end else begin
         irqStat_r <= (irqStat_r & ~irqClr) | irqSet;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irqEn_r <= '0;
      end else if (wrEn && wrAddr_r == OFS_IRQ_EN) begin
         irqEn_r <= hwdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         // use next status so irq follows an event by one edge only
         irq <= |(((irqStat_r & ~irqClr) | irqSet) & irqEn_r);
      end
   end

endmodule // port_error_rate_enable

// >>> sim/port_error_rate_enable_sva.sv
`timescale 1ns/10ps
module port_error_rate_enable_sva
   import rate_enable_pkg::*;
(
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic        hresp,
   input wire logic [31:0] errEvent,
   input wire logic        errorReport,
   input wire logic        irq
);
   // ==========================================================
   // shadow of the enable register
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   logic        taken;
   logic        wrEn_r;
   logic [31:0] enShadow_r;
   assign taken = hsel && htrans[1] && hready;
   always_ff @(posedge clk) begin
      if (srst) begin
         wrEn_r     <= 1'b0;
         enShadow_r <= '0;
      end else begin
         wrEn_r <= taken && hwrite && haddr == OFS_RATE_EN && hsize == 3'b010;
         if (wrEn_r) begin
            enShadow_r <= hwdata & RATE_EN_MASK;
         end
      end
   end
   // ==========================================================
   // checks
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   reset_clear_a: assert property (disable iff (1'b0) srst |=> hrdata == '0 && !irq)
      else $error("outputs not cleared by reset");
   enable_read_a: assert property (taken && !hwrite && haddr == OFS_RATE_EN
      |=> hrdata == $past(enShadow_r)) else $error("enable readback wrong");
   unmapped_zero_a: assert property (taken && !hwrite && haddr > OFS_IRQ_EN
      |=> hrdata == '0) else $error("unmapped read not zero");
   report_pulse_a: assert property (errorReport |=> !errorReport)
      else $error("report longer than one cycle");
   report_cause_a: assert property ((errEvent == '0 && !(taken && hwrite))[*3]
      |=> !errorReport) else $error("report without cause");
   irq_fall_a: assert property ($fell(irq) |-> $past(srst)
      || $past(taken && hwrite, 2) || $past(taken && hwrite, 3)) else $error("irq fell alone");
   irq_rise_a: assert property ($rose(irq) |-> $past(errEvent != '0)
      || $past(taken && hwrite, 2) || $past(taken && hwrite, 3))
      else $error("irq rose alone");
endmodule // port_error_rate_enable_sva

bind port_error_rate_enable port_error_rate_enable_sva chk_u (.clk(clk), .srst(srst),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
   .hresp(hresp), .errEvent(errEvent), .errorReport(errorReport), .irq(irq));

// >>> sim/link_partner.sv
`timescale 1ns/10ps
module link_partner
   import rate_enable_pkg::*;
#(
   parameter logic [31:0] ERR_WORD = 32'hA5A5_0001,
   parameter logic [31:0] RX_WORD  = 32'h5A5A_0002
) (
   input  wire logic          clk,
   input  wire logic          go,
   input  wire logic [4:0]    cls,
   input  wire implCause_type cause,
   output logic [31:0]        errEvent,
   output implCause_type      implCause,
   output captureWords_type   capWords
);
   // outside an event the qualifiers show the inverse, never stale values
   always_ff @(posedge clk) begin
      errEvent  <= go ? 32'h0000_0001 << cls : '0;
      implCause <= go ? cause : ~cause;
      capWords  <= go ? {ERR_WORD, RX_WORD} : ~{ERR_WORD, RX_WORD};
   end
endmodule // link_partner

// >>> sim/port_error_rate_enable_tb.sv
`timescale 1ns/10ps
module port_error_rate_enable_tb import rate_enable_pkg::*;;
   localparam logic [31:0] ERR_WORD = 32'hA5A5_0001;
   localparam logic [31:0] RX_WORD  = 32'h5A5A_0002;
   logic clk = 0, srst = 1, hsel = 0, hwrite = 0, go = 0;
   logic hready, hreadyout, hresp, errorReport, irq;
   logic [7:0] haddr = 0;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 0;
   logic [4:0] cls = 0;
   logic [31:0] hwdata = 0, hrdata, errEvent;
   implCause_type cause = '0, implCause;
   captureWords_type capWords;
   int fail_count = 0, check_count = 0, n;
   int reportCount = 0;
   assign hready = hreadyout;
   always #2 clk = ~clk;
   always @(posedge clk) begin
      if (errorReport === 1'b1) begin
         reportCount <= reportCount + 1;
      end
   end
   port_error_rate_enable dut_u (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .errEvent(errEvent),
      .implCause(implCause), .capWords(capWords), .errorReport(errorReport), .irq(irq));
   link_partner #(.ERR_WORD(ERR_WORD), .RX_WORD(RX_WORD)) partner_u (.clk(clk), .go(go),
      .cls(cls), .cause(cause), .errEvent(errEvent), .implCause(implCause),
      .capWords(capWords));
   // ==========================================================
   // tasks
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= a;
      hsize  <= 3'b010;
      do @(posedge clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, '0, q);
      chk($sformatf("reg %h", a), e, q);
   endtask
   task automatic fire(input int c, input implCause_type k);
      @(posedge clk);
      go    <= 1'b1;
      cls   <= c[4:0];
      cause <= k;
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // ==========================================================
   // tests
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      rc(OFS_RATE_EN, '0);
      wr(OFS_RATE_EN, 32'hFFFF_FFFF);
      rc(OFS_RATE_EN, RATE_EN_MASK);
      rc(8'hFC, '0);
      n = 0;
      for (int b = 0; b < 32; b++) begin
         fire(b, '0);
         n += int'(RATE_EN_MASK[b]);
         rc(OFS_COUNT, n);
      end
      wr(OFS_RATE_EN, 32'h0000_0200);
      wr(OFS_COUNT, '0);
      wr(OFS_DETECT, 32'h0000_0400);
      rc(OFS_COUNT, '0);
      wr(OFS_DETECT, 32'h0000_0600);
      rc(OFS_COUNT, 32'h0000_0001);
      wr(OFS_IRQ_CLR, 32'h0000_0003);
      wr(OFS_IRQ_EN, 32'h0000_0001);
      wr(OFS_THRESHOLD, 32'h0000_0002);
      fire(9, '0);
      chk("irq", 32'h0000_0001, {31'h0, irq});
      chk("errorReport", 32'h0000_0001, reportCount);
      wr(OFS_IRQ_CLR, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk("irq", '0, {31'h0, irq});
      wr(OFS_IRQ_EN, '0);
      wr(OFS_IRQ_CLR, 32'h0000_0003);
      wr(OFS_RATE_EN, 32'h2000_0001);
      wr(OFS_CAP_ATTR, '0);
      fire(0, implCause_type'(3'b010));
      rc(OFS_CAP_DATA, ERR_WORD);
      rc(OFS_CAP_ATTR, 32'h8000_0000);
      chk("irq", '0, {31'h0, irq});
      wr(OFS_IRQ_EN, 32'h0000_0002);
      repeat (2) @(posedge clk);
      chk("irq", 32'h0000_0001, {31'h0, irq});
      wr(OFS_CAP_ATTR, '0);
      fire(0, implCause_type'(3'b001));
      rc(OFS_CAP_DATA, RX_WORD);
      wr(OFS_CAP_ATTR, '0);
      fire(0, implCause_type'(3'b100));
      rc(OFS_CAP_DATA, ERR_WORD);
      wr(OFS_CAP_ATTR, '0);
      fire(0, '0);
      fire(29, '0);
      fire(9, '0);
      rc(OFS_CAP_ATTR, '0);
      tally_and_finish();
   end
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      tally_and_finish();
   end
endmodule // port_error_rate_enable_tb
